// ### bench/plams_partner.sv
// Far-side model: receiver bus, cursor address and transmitter status.
`timescale 1ns/1ps
module plams_partner (
    input wire logic clk, // System clock.
    output logic [6:0] rx_data, // Receiver byte lines.
    output logic rx_valid, // Byte complete.
    output logic [6:0] cursor_position, // Cursor position.
    output logic [4:0] cursor_line, // Cursor line.
    output logic transmitter_occupied, // Character held for sending.
    output logic cursor_char_protected // Character under cursor protected.
);
    logic [6:0] held_byte = 7'h00;
    logic [6:0] noise = 7'h2A;
    // ==========================================================
    // Receiver bus.
    // The lines wander every cycle while no complete byte stands.
    always @(posedge clk) noise <= ~noise + 7'h13;
    assign rx_data = rx_valid ? held_byte : noise;
    initial begin
        rx_valid = 1'b0;
        cursor_position = 7'h00;
        cursor_line = 5'h00;
        transmitter_occupied = 1'b0;
        cursor_char_protected = 1'b0;
    end
    // Presents a complete byte and keeps it until it is dropped.
    task automatic give(input logic [6:0] b);
        @(posedge clk);
        held_byte <= b;
        rx_valid <= 1'b1;
    endtask
    // Withdraws the byte.
    task automatic drop();
        @(posedge clk);
        rx_valid <= 1'b0;
    endtask
    // Moves the cursor.
    task automatic place(input logic [6:0] p, input logic [4:0] l);
        @(posedge clk);
        cursor_position <= p;
        cursor_line <= l;
    endtask
    // Sets the transmitter and protected-character status.
    task automatic flags(input logic x, input logic pb);
        @(posedge clk);
        transmitter_occupied <= x;
        cursor_char_protected <= pb;
    endtask
endmodule // plams_partner

// ### bench/tb_top.sv
// Self-checking bench for the microsequencer with an array model.
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hw_clear = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, perr, mode_reg, stage5, print_en, block_en, test_flag, prot;
    logic [3:0] opn_reg, seq_reg, ms, mo;
    logic [6:0] rx_data, cursor_position;
    logic [4:0] cursor_line;
    logic rx_valid, transmitter_occupied, cursor_char_protected, mm, m5, mp, ovr;
    logic [2:0] ma;
    logic [7:0] ovw;
    wire [44:0] outs;
    logic [44:0] seen = '0;
    logic [7:0] arr [0:16383];
    logic [31:0] r;
    int mismatches = 0;
    int num_checks = 0;
    int k;
    // ==========================================================
    // Clock, design and far side.
    always #2 clk = ~clk;
    plams_seq i_plams_seq (.clk(clk), .rst(rst), .hw_clear(hw_clear), .rx_data(rx_data),
        .rx_valid(rx_valid), .cursor_position(cursor_position), .cursor_line(cursor_line),
        .transmitter_occupied(transmitter_occupied), .cursor_char_protected(cursor_char_protected),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .system_strobe_n(outs[44]),
        .mode_reg(mode_reg), .opn_reg(opn_reg), .seq_reg(seq_reg), .sequence_stage_five(stage5),
        .print_enable(print_en), .block_send_enable(block_en), .program_test_flag(test_flag),
        .protect_enable_latch(prot), .pulse_ops_reg(outs[43:12]), .const_dest_reg(outs[11:4]),
        .const_value_reg(outs[3:0]));
    always @(posedge clk) if (!hw_clear) seen <= seen | {~outs[44], outs[43:0]};
    plams_partner i_plams_partner (.clk(clk), .rx_data(rx_data), .rx_valid(rx_valid),
        .cursor_position(cursor_position), .cursor_line(cursor_line),
        .transmitter_occupied(transmitter_occupied), .cursor_char_protected(cursor_char_protected));
    // ==========================================================
    // Behavioural model of the array and the sequencer state.
    task automatic inc();
        m5 = m5 | (ms == 4'hF);
        ms = ms + 4'h1;
    endtask
    task automatic app(input logic [7:0] w);
        if (!w[7] && w[6:4] == 3'h0) ms = w[3:0];
        else if (!w[7] && w[6:4] == 3'h1) {mm, mo, ms} = {1'b1, w[3:0], 4'h0};
        else if (w[7:3] == 5'h16) {mm, ms, m5, ma} = 9'h000;
        else begin
            if (!w[7] && w[6:4] == 3'h2) ma = w[3:1];
            if (w[7:3] == 5'h10) mp = 1'b1;
            if (w[7:3] == 5'h11) mp = 1'b0;
            inc();
        end
    endtask
    function automatic logic [13:0] adr();
        logic rng;
        logic [7:0] v;
        rng = (cursor_position >= 7'h50) || (cursor_line >= 5'h18);
        v = mm ? {mo, mp, transmitter_occupied, cursor_char_protected, ma[2]}
               : {m5, rx_valid ? rx_data : 7'h00};
        return {mm, rng, ms, v};
    endfunction
    // Runs the model until any short program path comes to rest.
    task automatic settle();
        @(posedge clk);
        repeat (64) begin
            if (hw_clear) {mm, mo, ms, m5, ma, mp} = {1'b1, 13'h0000};
            else app(ovr ? ovw : arr[adr()]);
        end
    endtask
    // ==========================================================
    // Bus cycles, comparisons and the closing verdict.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Polls the status word until it matches the model, then compares it and the state pins.
    task automatic chk();
        logic [13:0] e;
        int n;
        settle();
        e = {mp, ma, m5, mm, mo, ms};
        n = 0;
        do begin apb(1'b0, plams_pkg::OFF_STATUS, 32'h0); n++; end while (r[13:0] !== e && n < 40);
        cmp("status", {18'h0, e}, r);
        cmp("state pins", {18'h0, e}, {18'h0, prot, test_flag, block_en, print_en, stage5,
            mode_reg, opn_reg, seq_reg});
    endtask
    // Writes one word at the address the current state looks up, then checks.
    task automatic step(input logic [7:0] w);
        logic [13:0] a;
        settle();
        a = adr();
        arr[a] = w;
        apb(1'b1, plams_pkg::OFF_ADDR, {18'h0, a});
        apb(1'b1, plams_pkg::OFF_DATA, {24'h0, w});
        chk();
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #(4 * 90000);
        mismatches++;
        wrap_up();
    end
    // ==========================================================
    // Main sequence.
    initial begin
        ovr = 1'b0;
        ovw = 8'h00;
        void'($urandom(49));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, plams_pkg::OFF_CTRL, 32'h0);
        cmp("ctrl reset", 32'h0, r);
        apb(1'b0, plams_pkg::OFF_OVERRIDE, 32'h0);
        cmp("override reset", 32'h7F, r);
        chk();
        apb(1'b1, 8'h14, 32'h5);
        cmp("unmapped error", 32'h1, {31'h0, perr});
        apb(1'b0, plams_pkg::OFF_DATA, 32'h0);
        cmp("data read", 32'h0, r);
        // Every array word holds the sequencer at its own step.
        apb(1'b1, plams_pkg::OFF_ADDR, 32'h0);
        for (int a = 0; a < 16384; a++) begin
            arr[a] = {4'h0, a[11:8]};
            apb(1'b1, plams_pkg::OFF_DATA, {24'h0, arr[a]});
        end
        hw_clear <= 1'b0;
        chk();
        k = 1 + $urandom % 13;
        repeat (k) step(8'hFF);
        step(8'(k + 1 + $urandom % (14 - k)));
        i_plams_partner.place(7'h50, 5'h00);
        step(8'h02);
        i_plams_partner.place(7'h4F, 5'h17);
        step(8'hFF);
        i_plams_partner.place(7'h00, 5'h18);
        step(8'hFF);
        i_plams_partner.place(7'h00, 5'h00);
        i_plams_partner.flags(1'b1, 1'b0);
        step(8'hFF);
        i_plams_partner.flags(1'b0, 1'b1);
        step(8'hFF);
        i_plams_partner.flags(1'b0, 1'b0);
        step(8'h87);
        step(8'hFF);
        step(8'h2E);
        step(8'hFF);
        step({4'h1, 4'($urandom)});
        step(8'hB7);
        step(8'h0F);
        step(8'hFF);
        i_plams_partner.give(7'(1 + $urandom % 127));
        step({4'h1, 4'($urandom)});
        step(8'hB7);
        i_plams_partner.drop();
        chk();
        hw_clear <= 1'b1;
        chk();
        ovw = 8'h09;
        ovr = 1'b1;
        apb(1'b1, plams_pkg::OFF_OVERRIDE, 32'h9);
        apb(1'b1, plams_pkg::OFF_CTRL, 32'h1);
        hw_clear <= 1'b0;
        chk();
        cmp("pulses", 32'h41, seen[43:12]);
        cmp("loads", 32'h107F, 32'({seen[44], seen[11:0]}));
        wrap_up();
    end
endmodule // tb_top

// ### rtl/plams_array_mem.sv
// Decision array storage with a registered read port.
`timescale 1ns/1ps
module plams_array_mem #(
    parameter int AW = 14,
    parameter int DW = 8
) (
    input wire logic clk, // System clock.
    input wire logic rst, // Asynchronous reset.
    input wire logic wr_en, // Write strobe.
    input wire logic [AW-1:0] wr_addr, // Write address.
    input wire logic [DW-1:0] wr_data, // Write data.
    input wire logic [AW-1:0] rd_addr, // Lookup address.
    output logic [DW-1:0] rd_data // Registered lookup result.
);
    logic [DW-1:0] mem [0:(2**AW)-1];

    // Software loads the array contents one word at a time.
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // The lookup result comes out of a register one cycle later.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule // plams_array_mem

// ### rtl/plams_pkg.sv
// Constants and types shared by the microsequencer design files.
package plams_pkg;
    localparam int IN_W = 14;
    localparam int OUT_W = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_OVERRIDE = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_ADDR = 8'h0C;
    localparam logic [7:0] OFF_DATA = 8'h10;
    localparam logic [6:0] CUR_POS_LIMIT = 7'h50;
    localparam logic [4:0] CUR_LINE_LIMIT = 5'h18;
    localparam logic [2:0] DEST_SEQ = 3'h0;
    localparam logic [2:0] DEST_OPN = 3'h1;
    localparam logic [2:0] DEST_AUX = 3'h2;
    localparam logic [2:0] DEST_BUS_SRC = 3'h3;
    localparam logic [2:0] OP_NOP = 3'h7;
    localparam logic [2:0] OP_SET_PROT = 3'h0;
    localparam logic [2:0] OP_CLR_PROT = 3'h1;
    localparam logic [2:0] OP_IDLE = 3'h6;
    localparam int DEC_STATUS = 0;
    localparam logic [3:0] SEQ_RST = 4'h0;
    localparam logic [3:0] SEQ_LAST = 4'hF;
    localparam logic [3:0] OPN_RST = 4'h0;
    localparam logic MODE_RST = 1'b1;
    localparam int AUX_PRINT = 1;
    localparam int AUX_BLK = 2;
    localparam int AUX_TEST = 3;
    localparam int CTRL_TEST = 0;
    localparam logic [7:0] OVERRIDE_RST = 8'h7F;
    typedef enum logic {PLAMS_LOOKUP, PLAMS_EXECUTE} plams_phase_t;
endpackage

// ### rtl/plams_seq.sv
// Array-driven microsequencer with its sequence, mode and operation state.
`timescale 1ns/1ps
// What this block does
// (R01) The array reads fourteen inputs: six fixed, eight switched by mode.
// (R02) Idle mode reads the receiver byte, zero until a byte is complete.
// (R03) In idle mode the array classifies any non-zero bus word.
// (R04) The sequence counter steps by one each strobe unless loaded or cleared.
// (R05) Jumps load the counter with output bits one to four.
// (R06) Clear, operation load and return to idle clear the counter.
// (R07) Counter carry sets stage five; return to idle clears it.
// (R08) Low sequence bits feed both modes; stage five only idle mode.
// (R09) Out-of-range is high when position reaches 80 or line 24.
// (R10) The mode input picks the variable inputs; bus bits only in idle.
// (R11) Leaving idle loads a four-bit operation code and enters mode one.
// (R12) In mode one the operation bits replace stage five and three bus inputs.
// (R13) Operation code changes only by load; clear gives operation zero, mode one.
// (R14) The protect latch feeds the array in mode one.
// (R15) Transmitter-occupied is high while a character waits to be sent.
// (R16) Cursor-character-protected feeds the array in mode one.
// (R17) The test flag is set only by program; it is read back and feeds the array in mode one.
// (R18) Eight-bit output word; top bit low means load a constant.
// (R19) Bits seven to five pick the destination one of eight.
// (R20) Auxiliary register clears on clear and on return to idle.
// (R21) A test control replaces the array output with a software word.
// (R22) Top bit high means single pulses chosen by the other seven bits.
// (R23) The program issues return to idle when an operation completes.
// (R24) Mode one is entered on the strobe that loads the operation code.
// (R25) All state moves on the strobe, with clear taking priority.
module plams_seq #(
    parameter int AW = plams_pkg::IN_W
) (
    input wire logic clk, // System clock, 250 MHz.
    input wire logic rst, // Asynchronous reset.
    input wire logic hw_clear, // Hardware clear, level.
    input wire logic [6:0] rx_data, // Receiver byte.
    input wire logic rx_valid, // Receiver byte complete.
    input wire logic [6:0] cursor_position, // Cursor character position.
    input wire logic [4:0] cursor_line, // Cursor line.
    input wire logic transmitter_occupied, // Transmitter holds a character.
    input wire logic cursor_char_protected, // Character under cursor protected.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction.
    input wire logic [7:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error.
    output logic system_strobe_n, // Low in the execute cycle.
    output logic mode_reg, // Current mode.
    output logic [3:0] opn_reg, // Operation code.
    output logic [3:0] seq_reg, // Sequence bits one to four.
    output logic sequence_stage_five, // Fifth sequence stage.
    output logic print_enable, // Print enable.
    output logic block_send_enable, // Block transmit enable.
    output logic program_test_flag, // Program test flag.
    output logic protect_enable_latch, // Protect mode latch.
    output logic [31:0] pulse_ops_reg, // Single-pulse operations.
    output logic [7:0] const_dest_reg, // Constant destination strobes.
    output logic [3:0] const_value_reg // Constant value.
);
    // ==========================================================
    // Strobe phase
    // ==========================================================
    plams_pkg::plams_phase_t phase_reg;
    logic exec;
    logic [AW-1:0] array_addr;
    logic [7:0] array_word;
    logic out_of_range;
    logic [7:0] bus_word;
    logic [7:0] var_in;
    logic ctrl_test_reg;
    logic [7:0] override_reg;
    logic [AW-1:0] load_addr_reg;
    logic mem_wr;
    logic apb_wr;
    logic apb_setup;
    logic load_operation_register;
    logic go_idle;
    logic dest_seq;
    logic seq_clr;
    logic seq_incr;
    logic set_prot;
    logic clr_prot;

    plams_word_if w();

    // Lookup and execute alternate; execute is the system strobe.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_reg <= plams_pkg::PLAMS_LOOKUP;
        end else begin
            case (phase_reg)
                plams_pkg::PLAMS_LOOKUP: phase_reg <= plams_pkg::PLAMS_EXECUTE;
                default: phase_reg <= plams_pkg::PLAMS_LOOKUP;
            endcase
        end
    end

    assign exec = (phase_reg == plams_pkg::PLAMS_EXECUTE);

    // Strobe pin follows the phase that comes next.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            system_strobe_n <= 1'b1;
        end else begin
            system_strobe_n <= exec;
        end
    end

    // ==========================================================
    // Array inputs
    // ==========================================================
    // Bus reads zero until the receiver has a whole byte.
    assign bus_word = rx_valid ? {1'b0, rx_data} : 8'h00; // R02

    // Cursor outside the visible page.
    assign out_of_range = (cursor_position >= plams_pkg::CUR_POS_LIMIT) ||
                          (cursor_line >= plams_pkg::CUR_LINE_LIMIT); // R09

    // Variable inputs switch with the mode.
    always_comb begin
        if (mode_reg) begin
            var_in = {opn_reg, protect_enable_latch, transmitter_occupied,
                      cursor_char_protected, program_test_flag}; // R12 R14 R15 R16 R17
        end else begin
            var_in = {sequence_stage_five, bus_word[6:0]}; // R08 R10 R03
        end
    end

    // Fourteen inputs: mode, range, four sequence bits, eight variable.
    assign array_addr = {mode_reg, out_of_range, seq_reg, var_in}; // R01 R08

    plams_array_mem #(
        .AW(AW),
        .DW(plams_pkg::OUT_W)
    ) u_mem (
        .clk(clk),
        .rst(rst),
        .wr_en(mem_wr),
        .wr_addr(load_addr_reg),
        .wr_data(pwdata[7:0]),
        .rd_addr(array_addr),
        .rd_data(array_word)
    );

    // Test control swaps the array for the override word.
    assign w.word = ctrl_test_reg ? override_reg : array_word; // R21

    plams_word_dec u_dec (
        .w(w)
    );

    // ==========================================================
    // Decoded commands
    // ==========================================================
    assign load_operation_register = exec && w.dest_sel[plams_pkg::DEST_OPN]; // R11
    assign dest_seq = exec && w.dest_sel[plams_pkg::DEST_SEQ];
    assign go_idle = exec && w.pulses[8*plams_pkg::DEC_STATUS + plams_pkg::OP_IDLE]; // R23
    assign set_prot = exec && w.pulses[8*plams_pkg::DEC_STATUS + plams_pkg::OP_SET_PROT];
    assign clr_prot = exec && w.pulses[8*plams_pkg::DEC_STATUS + plams_pkg::OP_CLR_PROT];
    assign seq_clr = hw_clear || load_operation_register || go_idle; // R06
    assign seq_incr = exec && !seq_clr && !dest_seq; // R04

    // ==========================================================
    // Sequencer state
    // ==========================================================
    // Sequence counter: clear first, then jump, then step.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seq_reg <= plams_pkg::SEQ_RST;
        end else if (exec) begin
            if (seq_clr) begin
                seq_reg <= plams_pkg::SEQ_RST; // R06 R25
            end else if (dest_seq) begin
                seq_reg <= w.value; // R05
            end else begin
                seq_reg <= 4'(seq_reg + 4'h1); // R04
            end
        end
    end

    // Fifth stage is set by carry only, never loaded.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sequence_stage_five <= 1'b0;
        end else if (exec) begin
            if (hw_clear || go_idle) begin
                sequence_stage_five <= 1'b0; // R07 R20
            end else if (seq_incr && seq_reg == plams_pkg::SEQ_LAST) begin
                sequence_stage_five <= 1'b1; // R07
            end
        end
    end

    // Mode enters one with the operation load, leaves on return to idle.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_reg <= plams_pkg::MODE_RST;
        end else if (exec) begin
            if (hw_clear || load_operation_register) begin
                mode_reg <= 1'b1; // R13 R24
            end else if (go_idle) begin
                mode_reg <= 1'b0; // R23
            end
        end
    end

    // Operation code moves only by preset; clear selects operation zero.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            opn_reg <= plams_pkg::OPN_RST;
        end else if (exec) begin
            if (hw_clear) begin
                opn_reg <= plams_pkg::OPN_RST; // R13
            end else if (load_operation_register) begin
                opn_reg <= w.value; // R11 R13
            end
        end
    end

    // Auxiliary register; the fifth stage bit is kept by the carry logic.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            print_enable <= 1'b0;
            block_send_enable <= 1'b0;
            program_test_flag <= 1'b0;
        end else if (exec) begin
            if (hw_clear || go_idle) begin
                print_enable <= 1'b0; // R20
                block_send_enable <= 1'b0;
                program_test_flag <= 1'b0;
            end else if (w.dest_sel[plams_pkg::DEST_AUX]) begin
                print_enable <= w.value[plams_pkg::AUX_PRINT];
                block_send_enable <= w.value[plams_pkg::AUX_BLK];
                program_test_flag <= w.value[plams_pkg::AUX_TEST]; // R17
            end
        end
    end

    // Protect latch is set and cleared by program pulses.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            protect_enable_latch <= 1'b0;
        end else if (exec) begin
            if (hw_clear) begin
                protect_enable_latch <= 1'b0;
            end else if (set_prot) begin
                protect_enable_latch <= 1'b1; // R14
            end else if (clr_prot) begin
                protect_enable_latch <= 1'b0;
            end
        end
    end

    // Pulses and constant strobes go out for one cycle after a strobe.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pulse_ops_reg <= '0;
            const_dest_reg <= '0;
            const_value_reg <= '0;
        end else begin
            pulse_ops_reg <= exec ? w.pulses : 32'h0000_0000; // R22
            const_dest_reg <= exec ? w.dest_sel : 8'h00; // R19
            const_value_reg <= exec ? w.value : 4'h0;
        end
    end

    // ==========================================================
    // APB slave
    // ==========================================================
    assign apb_setup = psel && !penable;
    assign apb_wr = psel && penable && pready && pwrite;
    assign mem_wr = apb_wr && (paddr == plams_pkg::OFF_DATA);

    // Control, override and array load address.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_test_reg <= 1'b0;
            override_reg <= plams_pkg::OVERRIDE_RST;
            load_addr_reg <= '0;
        end else if (apb_wr) begin
            if (paddr == plams_pkg::OFF_CTRL) begin
                ctrl_test_reg <= pwdata[plams_pkg::CTRL_TEST]; // R21
            end else if (paddr == plams_pkg::OFF_OVERRIDE) begin
                override_reg <= pwdata[7:0];
            end else if (paddr == plams_pkg::OFF_ADDR) begin
                load_addr_reg <= pwdata[AW-1:0];
            end else if (paddr == plams_pkg::OFF_DATA) begin
                load_addr_reg <= AW'(load_addr_reg + 1'b1);
            end
        end
    end

    // Answer in the first access cycle; read data taken at setup.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= apb_setup;
            pslverr <= 1'b0;
            prdata <= '0;
            if (apb_setup) begin
                if (paddr == plams_pkg::OFF_CTRL) begin
                    prdata <= {31'h0, ctrl_test_reg};
                end else if (paddr == plams_pkg::OFF_OVERRIDE) begin
                    prdata <= {24'h0, override_reg};
                end else if (paddr == plams_pkg::OFF_STATUS) begin
                    prdata <= {18'h0, protect_enable_latch, program_test_flag,
                               block_send_enable, print_enable, sequence_stage_five,
                               mode_reg, opn_reg, seq_reg};
                end else if (paddr == plams_pkg::OFF_ADDR) begin
                    prdata <= {{(32-AW){1'b0}}, load_addr_reg};
                end else if (paddr != plams_pkg::OFF_DATA) begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    a_seq_step: assert property (@(posedge clk) disable iff (rst) // R04
        seq_incr |=> seq_reg == 4'($past(seq_reg) + 4'h1))
        else $error("sequence counter did not step");

    a_seq_jump: assert property (@(posedge clk) disable iff (rst) // R05
        (dest_seq && !seq_clr) |=> seq_reg == $past(w.value))
        else $error("jump did not load counter");

    a_seq_clear: assert property (@(posedge clk) disable iff (rst) // R06
        (exec && seq_clr) |=> seq_reg == plams_pkg::SEQ_RST)
        else $error("counter not cleared");

    a_stage_carry: assert property (@(posedge clk) disable iff (rst) // R07
        (seq_incr && seq_reg == plams_pkg::SEQ_LAST && !go_idle) |=> sequence_stage_five)
        else $error("carry lost");

    a_idle_clear: assert property (@(posedge clk) disable iff (rst) // R20
        go_idle && !hw_clear |=> !mode_reg && !sequence_stage_five && !program_test_flag)
        else $error("return to idle left state");

    a_mode_entry: assert property (@(posedge clk) disable iff (rst) // R24
        (load_operation_register && !hw_clear) |=> mode_reg && opn_reg == $past(w.value))
        else $error("operation load missed");

    a_opn_hold: assert property (@(posedge clk) disable iff (rst) // R13
        !load_operation_register && !(exec && hw_clear) |=> $stable(opn_reg))
        else $error("operation code moved");

    a_clear_power: assert property (@(posedge clk) disable iff (rst) // R13
        (exec && hw_clear) |=> mode_reg && opn_reg == 4'h0 ##1 $stable(mode_reg))
        else $error("clear did not select operation zero");

    a_mux_mode: assert property (@(posedge clk) disable iff (rst) // R12
        mode_reg |-> array_addr[7:4] == opn_reg && array_addr[13])
        else $error("operation bits not routed");

    a_range_in: assert property (@(posedge clk) disable iff (rst) // R09
        (cursor_position < 7'h50 && cursor_line < 5'h18) |-> !array_addr[12])
        else $error("range input wrong");

    a_strobe_alt: assert property (@(posedge clk) disable iff (rst) // R25
        exec |=> !exec ##1 exec)
        else $error("strobe phase broken");
endmodule // plams_seq

// ### rtl/plams_word_dec.sv
// Decoder of the array output word into loads and single pulses.
`timescale 1ns/1ps
module plams_word_dec (
    plams_word_if.dec w // Word in, decoded fields out.
);
    // One-of-eight decode; code seven is no operation when masked.
    function automatic logic [7:0] plams_one_of_eight(input logic [2:0] code, input logic en,
                                                      input logic nop7);
        logic [7:0] r;
        r = '0;
        if (en && !(nop7 && code == plams_pkg::OP_NOP)) begin
            r[code] = 1'b1;
        end
        return r;
    endfunction

    // Constant-load words carry destination and value.
    assign w.is_const = ~w.word[7]; // R18
    assign w.value = w.word[3:0]; // R05
    assign w.dest_sel = plams_one_of_eight(w.word[6:4], ~w.word[7], 1'b0); // R19

    // Four pulse decoders; bit six picks the pair that is live.
    for (genvar d = 0; d < 4; d++) begin : g_dec
        assign w.pulses[8*d +: 8] = plams_one_of_eight(
            (d % 2 == 0) ? w.word[5:3] : w.word[2:0],
            w.word[7] & (w.word[6] == (d >= 2)), 1'b1); // R22
    end
endmodule // plams_word_dec

// ### rtl/plams_word_if.sv
// Array output word and its decoded meanings.
`timescale 1ns/1ps
interface plams_word_if;
    logic [7:0] word;
    logic is_const;
    logic [7:0] dest_sel;
    logic [3:0] value;
    logic [31:0] pulses;
    modport src(output word, input is_const, input dest_sel, input value, input pulses);
    modport dec(input word, output is_const, output dest_sel, output value, output pulses);
endinterface
